// *** core/cbsr_consts.vh ***
// Offsets, field positions, reset values and timing counts of the colour and exposure registers
`ifndef CBSR_CONSTS_VH
`define CBSR_CONSTS_VH

// Byte offsets, decoded on haddr[11:0]
`define CBSR_OFS_COLOUR   12'h80c
`define CBSR_OFS_EXPO     12'h81c
`define CBSR_HSIZE_WORD   3'b010

// Flag positions; register bit 0 is the word's MSB
`define CBSR_B_PRESENT    31
`define CBSR_B_ABS        30
`define CBSR_B_ONEPUSH    26
`define CBSR_B_ONOFF      25
`define CBSR_B_AUTO       24

// Level fields
`define CBSR_BLUE_MSB     23
`define CBSR_BLUE_LSB     12
`define CBSR_RED_MSB      11
`define CBSR_RED_LSB      0
`define CBSR_EXPO_MSB     11
`define CBSR_EXPO_LSB     0

// Field limits and defaults
`define CBSR_LVL_MIN      12'h010
`define CBSR_LVL_MAX      12'h0ff
`define CBSR_LVL_UNITY    12'h060
`define CBSR_BLUE_DEF     12'h0a0
`define CBSR_RED_DEF      12'h073
`define CBSR_EXPO_MIN     12'h001
`define CBSR_EXPO_MONO    12'h1f4
`define CBSR_EXPO_COL     12'h2ee

// Exposure time base
`define CBSR_TB_US        20
`define CBSR_CLK_MHZ      40
`define CBSR_TB_CYC       (`CBSR_TB_US * `CBSR_CLK_MHZ)

`endif

// *** core/cbsr_expo_timer.v ***
// Exposure timer: holds the exposure for value times the time base
`timescale 1ns/1ps
module cbsr_expo_timer #(
   parameter [31:0] TB_CYC = 32'd800
) (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        start,
   input  wire [11:0] value,
   output wire        active,
   output wire        done
);

   reg        active_q;
   reg        done_q;
   reg [11:0] units_q;
   reg [31:0] pre_q;

   assign active = active_q;
   assign done   = done_q;

   // Value is latched at start, so a later write only affects the next exposure
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         active_q <= 1'b0;
         done_q   <= 1'b0;
         units_q  <= 12'h000;
         pre_q    <= 32'h0000_0000;
      end else begin
         done_q <= 1'b0;
         if (!active_q) begin
            if (start && (value != 12'h000)) begin
               active_q <= 1'b1;
               units_q  <= value;
               pre_q    <= 32'h0000_0000;
            end
         end else if (pre_q == (TB_CYC - 32'd1)) begin
            pre_q <= 32'h0000_0000;
            if (units_q == 12'h001) begin
               active_q <= 1'b0;
               done_q   <= 1'b1;
            end else begin
               units_q <= units_q - 12'h001;
            end
         end else begin
            pre_q <= pre_q + 32'd1;
         end
      end
   end

endmodule // cbsr_expo_timer

// *** core/cbsr_regs.v ***
// Colour balance and exposure control registers on AHB-Lite, with colour gain and exposure timer
`timescale 1ns/1ps
`include "cbsr_consts.vh"

module cbsr_regs #(
   parameter [31:0] TB_CYC = `CBSR_TB_CYC
) (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire [31:0] hrdata,
   output wire        hreadyout,
   output wire        hresp,
   input  wire        colour_variant,
   input  wire        expo_start,
   output wire        expo_active,
   output wire        expo_done,
   output wire [11:0] blue_level,
   output wire [11:0] red_level,
   output wire [11:0] expo_value,
   input  wire        pix_valid_in,
   input  wire [7:0]  pix_red_in,
   input  wire [7:0]  pix_green_in,
   input  wire [7:0]  pix_blue_in,
   output wire        pix_valid_out,
   output wire [7:0]  pix_red_out,
   output wire [7:0]  pix_green_out,
   output wire [7:0]  pix_blue_out
);

   // Scale one colour component by level/unity, saturating at full scale
   function [7:0] cbsr_scale;
      input [7:0]  comp;
      input [11:0] lvl;
      reg   [19:0] prod;
      reg   [19:0] quo;
      begin
         prod = {12'h000, comp} * {8'h00, lvl};
         quo  = prod / {8'h00, `CBSR_LVL_UNITY};
         if (quo > 20'h000ff) begin
            cbsr_scale = 8'hff;
         end else begin
            cbsr_scale = quo[7:0];
         end
      end
   endfunction

   // Accept only levels inside the documented range
   function cbsr_lvl_ok;
      input [11:0] lvl;
      begin
         cbsr_lvl_ok = (lvl >= `CBSR_LVL_MIN) && (lvl <= `CBSR_LVL_MAX);
      end
   endfunction

   // Register select from a byte offset: bit 0 colour, bit 1 exposure
   function [1:0] cbsr_dec;
      input [11:0] ofs;
      begin
         cbsr_dec = 2'b00;
         if (ofs == `CBSR_OFS_COLOUR) begin
            cbsr_dec = 2'b01;
         end
         if (ofs == `CBSR_OFS_EXPO) begin
            cbsr_dec = 2'b10;
         end
      end
   endfunction

   // Variant strap and one-cycle default load after reset
   reg        init_done_q;
   reg        colour_q;

   // Register fields
   reg [11:0] blue_q;
   reg [11:0] blue_d;
   reg [11:0] red_q;
   reg [11:0] red_d;
   reg [11:0] expo_q;
   reg [11:0] expo_d;

   // AHB data phase state
   reg        wr_pend_q;
   reg [11:0] wr_addr_q;
   reg [31:0] rdata_q;
   reg [31:0] rdata_d;

   wire        addr_phase;
   wire        wr_word;
   wire        wr_take;
   wire        rd_take;
   wire [1:0]  wr_sel;
   wire [1:0]  rd_sel;
   wire        wr_colour;
   wire        wr_expo;
   wire [11:0] wr_blue;
   wire [11:0] wr_red;
   wire [11:0] wr_expo_val;
   reg  [31:0] colour_word;
   reg  [31:0] expo_word;

   // One wait state right after reset while the defaults are loaded
   assign hreadyout = init_done_q;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_q;

   // Sizes other than a word are accepted but never stored
   assign wr_word    = (hsize == `CBSR_HSIZE_WORD);
   assign addr_phase = hsel && htrans[1] && hready && init_done_q;
   assign wr_take    = addr_phase && hwrite && wr_word;
   assign rd_take    = addr_phase && !hwrite;

   assign wr_sel    = cbsr_dec(wr_addr_q);
   assign rd_sel    = cbsr_dec(haddr[11:0]);
   assign wr_colour = wr_pend_q && wr_sel[0] && colour_q;
   assign wr_expo   = wr_pend_q && wr_sel[1];

   // Only the level fields are taken from hwdata; flag bits are never stored
   assign wr_blue     = hwdata[`CBSR_BLUE_MSB:`CBSR_BLUE_LSB];
   assign wr_red      = hwdata[`CBSR_RED_MSB:`CBSR_RED_LSB];
   assign wr_expo_val = hwdata[`CBSR_EXPO_MSB:`CBSR_EXPO_LSB];

   // Strap is sampled in the first clock after reset release
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         init_done_q <= 1'b0;
         colour_q    <= 1'b0;
      end else if (!init_done_q) begin
         init_done_q <= 1'b1;
         colour_q    <= colour_variant;
      end
   end

   // Next blue level; an out-of-range write leaves the field unchanged
   always @* begin
      blue_d = blue_q;
      if (!init_done_q) begin
         if (colour_variant) begin
            blue_d = `CBSR_BLUE_DEF;
         end else begin
            blue_d = 12'h000;
         end
      end else if (wr_colour && cbsr_lvl_ok(wr_blue)) begin
         blue_d = wr_blue;
      end
   end

   // Red is checked on its own, so one bad field does not block the other
   always @* begin
      red_d = red_q;
      if (!init_done_q) begin
         if (colour_variant) begin
            red_d = `CBSR_RED_DEF;
         end else begin
            red_d = 12'h000;
         end
      end else if (wr_colour && cbsr_lvl_ok(wr_red)) begin
         red_d = wr_red;
      end
   end

   // Next exposure value; zero is refused
   always @* begin
      expo_d = expo_q;
      if (!init_done_q) begin
         if (colour_variant) begin
            expo_d = `CBSR_EXPO_COL;
         end else begin
            expo_d = `CBSR_EXPO_MONO;
         end
      end else if (wr_expo && (wr_expo_val >= `CBSR_EXPO_MIN)) begin
         expo_d = wr_expo_val;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         blue_q <= 12'h000;
         red_q  <= 12'h000;
         expo_q <= 12'h000;
      end else begin
         blue_q <= blue_d;
         red_q  <= red_d;
         expo_q <= expo_d;
      end
   end

   // Read words are built from the next values so a write just before a read is seen
   always @* begin
      colour_word                                = 32'h0000_0000;
      colour_word[`CBSR_B_PRESENT]               = colour_q;
      colour_word[`CBSR_B_ABS]                   = 1'b0;
      colour_word[`CBSR_B_ONEPUSH]               = 1'b0;
      colour_word[`CBSR_B_ONOFF]                 = colour_q;
      colour_word[`CBSR_B_AUTO]                  = 1'b0;
      colour_word[`CBSR_BLUE_MSB:`CBSR_BLUE_LSB] = blue_d;
      colour_word[`CBSR_RED_MSB:`CBSR_RED_LSB]   = red_d;
   end

   // Exposure word: only the value field is writable
   always @* begin
      expo_word                                = 32'h0000_0000;
      expo_word[`CBSR_B_PRESENT]               = 1'b1;
      expo_word[`CBSR_B_ABS]                   = 1'b0;
      expo_word[`CBSR_B_ONEPUSH]               = 1'b0;
      expo_word[`CBSR_B_ONOFF]                 = 1'b1;
      expo_word[`CBSR_B_AUTO]                  = 1'b0;
      expo_word[`CBSR_EXPO_MSB:`CBSR_EXPO_LSB] = expo_d;
   end

   always @* begin
      rdata_d = rdata_q;
      if (rd_take) begin
         case (rd_sel)
            2'b01:   rdata_d = colour_word;
            2'b10:   rdata_d = expo_word;
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // Address phase capture; unmapped writes are accepted and dropped
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 12'h000;
      end else begin
         wr_pend_q <= wr_take;
         if (wr_take) begin
            wr_addr_q <= haddr[11:0];
         end
      end
   end

   // Read data stands until the next read is taken
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign blue_level = blue_q;
   assign red_level  = red_q;
   assign expo_value = expo_q;

   // Colour gain stage: red and blue are scaled on a colour part, green passes through
   wire [7:0]  comp_in  [0:1];
   wire [11:0] comp_lvl [0:1];
   wire [7:0]  comp_out [0:1];
   reg  [7:0]  green_q;
   reg         pix_valid_q;

   assign comp_in[0]  = pix_red_in;
   assign comp_in[1]  = pix_blue_in;
   assign comp_lvl[0] = red_q;
   assign comp_lvl[1] = blue_q;

   // Each lane owns its register, so no array has two drivers
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_gain
         reg [7:0] comp_q;
         assign comp_out[ch] = comp_q;
         // A monochrome part has no colour balance, so pixels pass unchanged
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               comp_q <= 8'h00;
            end else if (pix_valid_in) begin
               if (colour_q) begin
                  comp_q <= cbsr_scale(comp_in[ch], comp_lvl[ch]);
               end else begin
                  comp_q <= comp_in[ch];
               end
            end
         end
      end
   endgenerate

   // Valid is delayed every cycle; pixel data hold while valid is low
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pix_valid_q <= 1'b0;
      end else begin
         pix_valid_q <= pix_valid_in;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         green_q <= 8'h00;
      end else if (pix_valid_in) begin
         green_q <= pix_green_in;
      end
   end

   assign pix_valid_out = pix_valid_q;
   assign pix_red_out   = comp_out[0];
   assign pix_blue_out  = comp_out[1];
   assign pix_green_out = green_q;

   // Exposure length is value times the time base
   cbsr_expo_timer #(
      .TB_CYC (TB_CYC)
   ) u_expo_timer (
      .hclk    (hclk),
      .hresetn (hresetn),
      .start   (expo_start && init_done_q),
      .value   (expo_q),
      .active  (expo_active),
      .done    (expo_done)
   );

endmodule // cbsr_regs

// *** verif/cbsr_regs_assertions.sv ***
// Property checker for the colour balance and exposure register block
`timescale 1ns/1ps
module cbsr_regs_chk #(
   parameter [31:0] TB_CYC = 32'd800
) (
   input wire        hclk,
   input wire        hresetn,
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire [31:0] hrdata,
   input wire        hreadyout,
   input wire        hresp,
   input wire        colour_variant,
   input wire        expo_start,
   input wire        expo_active,
   input wire        expo_done,
   input wire [11:0] blue_level,
   input wire [11:0] red_level,
   input wire [11:0] expo_value
);
   wire       rd_q = hsel && htrans[1] && !hwrite && hreadyout;
   wire       rd_c = rd_q && haddr[11:0] == 12'h80c;
   wire       rd_e = rd_q && haddr[11:0] == 12'h81c;
   reg [31:0] cnt_q;
   reg [11:0] val_q;
   // Active length so far, and the value latched at start; later writes do not count
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 32'h0;
         val_q <= 12'h0;
      end else begin
         cnt_q <= expo_active ? cnt_q + 32'h1 : 32'h0;
         if (expo_start && !expo_active && hreadyout)
            val_q <= expo_value;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("error response seen");
   chk_colour_flags: assert property (rd_c |=>
      hrdata[31:24] == {colour_variant, 5'h0, colour_variant, 1'b0})
      else $error("colour flag bits wrong");
   chk_expo_flags: assert property (rd_e |=> hrdata[31:12] == 20'h82000)
      else $error("exposure flag bits wrong");
   chk_expo_field: assert property (rd_e |=> hrdata[11:0] == expo_value)
      else $error("exposure field readback wrong");
   chk_expo_nonzero: assert property (hreadyout |-> expo_value != 12'h0)
      else $error("exposure value zero");
   chk_blue_range: assert property (hreadyout && colour_variant |->
      blue_level inside {[12'h010:12'h0ff]})
      else $error("blue level out of range");
   chk_red_range: assert property (hreadyout && colour_variant |->
      red_level inside {[12'h010:12'h0ff]})
      else $error("red level out of range");
   chk_expo_start: assert property (expo_start && !expo_active && hreadyout |=> expo_active)
      else $error("exposure did not start");
   chk_expo_len: assert property ($fell(expo_active) |->
      cnt_q == val_q * TB_CYC && expo_done)
      else $error("exposure length wrong");
   chk_done_pulse: assert property (expo_done |=> !expo_done)
      else $error("done longer than one cycle");
   cov_rd_c: cover property (rd_c);
   cov_rd_e: cover property (rd_e);
   cov_expo: cover property ($fell(expo_active));
   cov_start_busy: cover property (expo_start && expo_active);
endmodule // cbsr_regs_chk

bind cbsr_regs cbsr_regs_chk #(.TB_CYC(TB_CYC)) u_chk (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hrdata, .hreadyout, .hresp, .colour_variant, .expo_start,
   .expo_active, .expo_done, .blue_level, .red_level, .expo_value);

// *** verif/tb.sv ***
// Self-checking bench for the colour balance and exposure register block
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin bad_count++; \
   $display("unexpected %s expected %h seen %h", n, e, s); end end
module tb;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, colour_variant = 1;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic        hreadyout, hresp, expo_start = 0, expo_active, expo_done;
   logic [11:0] blue_level, red_level, expo_value, b, r, e, ve;
   logic        pix_valid_in = 0, pix_valid_out;
   logic [7:0]  pix_red_in = 0, pix_green_in = 0, pix_blue_in = 0;
   logic [7:0]  pix_red_out, pix_green_out, pix_blue_out;
   logic [15:0] lf = 16'h682a;
   logic [8:0]  cb [5] = '{9'h00f, 9'h010, 9'h060, 9'h0ff, 9'h100};
   int          bad_count = 0, n_compared = 0, n;

   // Short time base keeps exposures a few cycles long
   cbsr_regs #(.TB_CYC(32'd4)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .colour_variant,
      .expo_start, .expo_active, .expo_done, .blue_level, .red_level, .expo_value,
      .pix_valid_in, .pix_red_in, .pix_green_in, .pix_blue_in, .pix_valid_out,
      .pix_red_out, .pix_green_out, .pix_blue_out);

   always #12.5 hclk = ~hclk;

   function automatic [15:0] nx(input [15:0] x);
      nx = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   function automatic [7:0] gn(input [7:0] c, input [11:0] l);
      int v;
      v = c * l / 96;
      gn = v > 255 ? 8'hff : v[7:0];
   endfunction

   task upd(inout [11:0] f, input [8:0] v);
      if (v >= 9'd16 && v <= 9'd255) f = {3'h0, v};
   endtask

   task xfer(input w, input [31:0] a, input [31:0] d);
      @(posedge hclk);
      hsel <= 1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task rst(input cv);
      @(posedge hclk);
      hresetn <= 0;
      colour_variant <= cv;
      repeat (3) @(posedge hclk);
      hresetn <= 1;
      repeat (2) @(posedge hclk);
   endtask

   task finish_test;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      #500000;
      bad_count++;
      finish_test;
   end

   initial begin
      rst(1);
      b = 12'h0a0;
      r = 12'h073;
      e = 12'h2ee;
      xfer(0, 32'h80c, 0); `CHK("colour reset", {8'h82, b, r}, rd)
      xfer(0, 32'h81c, 0); `CHK("expo reset", {20'h82000, e}, rd)
      xfer(1, 32'h810, 32'hffffffff);
      xfer(0, 32'h810, 0); `CHK("unmapped", 32'h0, rd)
      // A byte-sized write is answered but must not land
      hsize <= 3'h0;
      xfer(1, 32'h81c, 32'h00000123);
      hsize <= 3'h2;
      xfer(0, 32'h81c, 0); `CHK("byte write", {20'h82000, e}, rd)
      for (int i = 0; i < 24; i++) begin
         lf = nx(lf);
         // Corner levels first, then random ones
         xfer(1, 32'h80c, {8'hff, 3'h0, i < 5 ? cb[i] : lf[8:0], 3'h0, i < 5 ? cb[4-i] : lf[15:7]});
         upd(b, i < 5 ? cb[i] : lf[8:0]);
         upd(r, i < 5 ? cb[4-i] : lf[15:7]);
         xfer(0, 32'h80c, 0); `CHK("colour rw", {8'h82, b, r}, rd)
         ve = (i % 5 == 0) ? 12'h0 : (i == 1 ? 12'hfff : lf[11:0]);
         xfer(1, 32'h81c, {20'hfffff, ve});
         if (ve != 12'h0) e = ve;
         xfer(0, 32'h81c, 0); `CHK("expo rw", {20'h82000, e}, rd)
         `CHK("levels", {b, r, e}, {blue_level, red_level, expo_value})
         @(posedge hclk);
         pix_valid_in <= 1;
         {pix_red_in, pix_green_in, pix_blue_in} <= {lf[7:0], lf[15:8], lf[11:4]};
         @(posedge hclk);
         pix_valid_in <= 0;
         #1;
         `CHK("pixel", {gn(pix_red_in, r), pix_green_in, gn(pix_blue_in, b)}, {pix_red_out, pix_green_out, pix_blue_out})
         `CHK("pixel valid", 1'b1, pix_valid_out)
         @(posedge hclk);
         #1;
         `CHK("pixel idle", 1'b0, pix_valid_out)
      end
      xfer(1, 32'h81c, 32'h3);
      @(posedge hclk);
      expo_start <= 1;
      // Start stays up one cycle into the exposure, where it must be ignored
      repeat (2) @(posedge hclk);
      expo_start <= 0;
      #1;
      n = 1;
      while (expo_active === 1'b1) begin
         n++;
         @(posedge hclk);
         #1;
      end
      `CHK("expo cycles", 32'd12, n)
      `CHK("expo done", 1'b1, expo_done)
      rst(0);
      xfer(1, 32'h80c, 32'h0a0073);
      xfer(0, 32'h80c, 0); `CHK("mono colour", 32'h0, rd)
      xfer(0, 32'h81c, 0); `CHK("mono expo", 32'h820001f4, rd)
      @(posedge hclk);
      pix_valid_in <= 1;
      {pix_red_in, pix_green_in, pix_blue_in} <= 24'h3c5aa7;
      @(posedge hclk);
      pix_valid_in <= 0;
      #1;
      `CHK("mono pixel", 24'h3c5aa7, {pix_red_out, pix_green_out, pix_blue_out})
      finish_test;
   end
endmodule // tb
